// [dosc_ctrl.sv]
/*
 * dac output state control: apb register file, load and clear actions,
 * software reset, output-state decode and feedback resistor select.
 * assumes an apb master on pclk and asynchronous active-low pins
 * load_output_n and clear_to_code_n from the board.
 */
// Functional notes
// - clear loads clear code, format applied
// - reset action restores power-on state
// - load ignored while clear pin low
// - power-on resets every register to default
// - power-on: float bit set, refs off, clamped
// - clamp persists until control register changed
// - normal mode starts at negative reference
// - decode float and clamp into output state
// - select one: resistors paralleled, unity gain
// - select zero: matched resistors, gain two
// - clamp overrules float bit
// - format zero twos complement, one offset
// - load moves pending value to dac
// - clear ignored while load pin low
module dosc_ctrl #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic load_output_n,
    input wire logic clear_to_code_n,
    output logic [dosc_pkg::DAC_W-1:0] dac_code,
    output dosc_pkg::dosc_ostate_type out_state
);

    localparam int DW = dosc_pkg::DAC_W;

    typedef struct packed {
        logic [DW-1:0] pend;
        logic [DW-1:0] clr_code;
        logic [DW-1:0] dac;
        logic [DW-1:0] code;
        dosc_pkg::dosc_ctrl_type ctrl;
        dosc_pkg::dosc_ostate_type ost;
        logic [31:0] prdata;
        logic rd_ok;
        logic ld_prev;
        logic clr_prev;
    } dosc_state_type;

    dosc_state_type s_r;
    dosc_state_type s_nxt;

    logic [1:0] pins_q;
    logic ld_pin;
    logic clr_pin;
    logic wr;
    logic sw_load;
    logic sw_clear;
    logic sw_reset;
    logic load_ev;
    logic clear_ev;
    logic mapped;

    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_chk
        $error("dosc_ctrl: address width must be 5 to 32");
    end

    // full word address match
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    // dac register to output code under the selected format
    function automatic logic [DW-1:0] to_code(input logic [DW-1:0] v,
                                              input logic offset_bin);
        to_code = offset_bin ? v : {~v[DW-1], v[DW-2:0]};
    endfunction : to_code

    // decode of the control bits into the analog state
    function automatic dosc_pkg::dosc_ostate_type decode(
        input dosc_pkg::dosc_ctrl_type c);
        decode.clamped = c.gnd_clamp;
        decode.floated = c.dac_float & ~c.gnd_clamp;
        decode.normal = ~c.dac_float & ~c.gnd_clamp;
        decode.ref_connect = ~c.dac_float & ~c.gnd_clamp;
        decode.fb_parallel = c.fb_sel;
    endfunction : decode

    // pins come from outside the clock domain
    dosc_sync #(
        .W(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({load_output_n, clear_to_code_n}),
        .q(pins_q)
    );

    assign ld_pin = pins_q[1];
    assign clr_pin = pins_q[0];

    // apb handshake: one wait-free access once the read data is staged
    assign pready = psel & penable & s_r.rd_ok & ce;
    assign mapped = hit(paddr, dosc_pkg::ADDR_PEND)
        | hit(paddr, dosc_pkg::ADDR_CTRL)
        | hit(paddr, dosc_pkg::ADDR_CLRCODE)
        | hit(paddr, dosc_pkg::ADDR_SWCTL)
        | hit(paddr, dosc_pkg::ADDR_DAC)
        | hit(paddr, dosc_pkg::ADDR_STAT);
    assign pslverr = pready & ~mapped;
    assign wr = pready & pwrite & mapped;

    // action bits exist only in the write cycle, never stored
    assign sw_load = wr & hit(paddr, dosc_pkg::ADDR_SWCTL)
        & pwdata[dosc_pkg::SW_LOAD];
    assign sw_clear = wr & hit(paddr, dosc_pkg::ADDR_SWCTL)
        & pwdata[dosc_pkg::SW_CLEAR];
    assign sw_reset = wr & hit(paddr, dosc_pkg::ADDR_SWCTL)
        & pwdata[dosc_pkg::SW_RESET];

    // pin falling edge and action bit share the interlocks
    assign load_ev = (sw_load | (s_r.ld_prev & ~ld_pin)) & clr_pin;
    assign clear_ev = (sw_clear | (s_r.clr_prev & ~clr_pin)) & ld_pin;

    // next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ld_prev = ld_pin;
        s_nxt.clr_prev = clr_pin;
        if (wr && hit(paddr, dosc_pkg::ADDR_PEND))
        begin
            s_nxt.pend = pwdata[DW-1:0];
        end
        if (wr && hit(paddr, dosc_pkg::ADDR_CTRL))
        begin
            s_nxt.ctrl = pwdata[dosc_pkg::CTRL_FMT:dosc_pkg::CTRL_FB];
        end
        if (wr && hit(paddr, dosc_pkg::ADDR_CLRCODE))
        begin
            s_nxt.clr_code = pwdata[DW-1:0];
        end
        if (load_ev)
        begin
            s_nxt.dac = s_r.pend;
        end
        if (clear_ev)
        begin
            s_nxt.dac = s_r.clr_code;
        end
        if (sw_reset)
        begin
            s_nxt.pend = dosc_pkg::PEND_RST;
            s_nxt.clr_code = dosc_pkg::CLRCODE_RST;
            s_nxt.dac = dosc_pkg::DAC_RST;
            s_nxt.ctrl = dosc_pkg::CTRL_RST;
        end
        s_nxt.code = to_code(s_nxt.dac, s_nxt.ctrl.fmt_offset_bin);
        s_nxt.ost = decode(s_nxt.ctrl);
        s_nxt.rd_ok = psel & ~pready;
        if (psel && !pready)
        begin
            s_nxt.prdata = '0;
            case (1'b1)
                hit(paddr, dosc_pkg::ADDR_PEND):
                    s_nxt.prdata[DW-1:0] = s_r.pend;
                hit(paddr, dosc_pkg::ADDR_CTRL):
                    s_nxt.prdata[dosc_pkg::CTRL_FMT:dosc_pkg::CTRL_FB] = s_r.ctrl;
                hit(paddr, dosc_pkg::ADDR_CLRCODE):
                    s_nxt.prdata[DW-1:0] = s_r.clr_code;
                hit(paddr, dosc_pkg::ADDR_DAC):
                    s_nxt.prdata[DW-1:0] = s_r.dac;
                hit(paddr, dosc_pkg::ADDR_STAT):
                    s_nxt.prdata[$bits(dosc_pkg::dosc_ostate_type)-1:0] = s_r.ost;
                default:
                    s_nxt.prdata = '0;
            endcase
        end
    end

    // power-on state; all state frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r.pend <= dosc_pkg::PEND_RST;
            s_r.clr_code <= dosc_pkg::CLRCODE_RST;
            s_r.dac <= dosc_pkg::DAC_RST;
            s_r.code <= '0;
            s_r.ctrl <= dosc_pkg::CTRL_RST;
            s_r.ost <= '{fb_parallel: 1'b0, ref_connect: 1'b0,
                         clamped: 1'b1, floated: 1'b0, normal: 1'b0};
            s_r.prdata <= '0;
            s_r.rd_ok <= 1'b0;
            s_r.ld_prev <= 1'b1;
            s_r.clr_prev <= 1'b1;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata = s_r.prdata;
    assign dac_code = s_r.code;
    assign out_state = s_r.ost;

    // control register write strobe for checks
    logic ctrl_wr;
    assign ctrl_wr = wr & hit(paddr, dosc_pkg::ADDR_CTRL);

    property p_clear_code;
        @(posedge pclk) disable iff (!presetn)
        sw_clear && ld_pin && !sw_reset |=> s_r.dac == $past(s_r.clr_code);
    endproperty
    a_clear_code: assert property (p_clear_code)
        else $error("clear action did not load clear code");

    property p_soft_reset;
        @(posedge pclk) disable iff (!presetn)
        sw_reset |=> s_r.ctrl == dosc_pkg::CTRL_RST
            && s_r.dac == dosc_pkg::DAC_RST ##1 out_state.clamped;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("reset action did not restore power-on state");

    property p_load_blocked;
        @(posedge pclk) disable iff (!presetn)
        ce && !clr_pin && !clear_ev && !sw_reset |=> $stable(s_r.dac);
    endproperty
    a_load_blocked: assert property (p_load_blocked)
        else $error("load acted while clear pin low");

    property p_clamp_hold;
        @(posedge pclk) disable iff (!presetn)
        $fell(out_state.clamped) |-> $past(ctrl_wr, 2) || $past(ctrl_wr);
    endproperty
    a_clamp_hold: assert property (p_clamp_hold)
        else $error("clamp released without control write");

    property p_state_decode;
        @(posedge pclk) disable iff (!presetn)
        out_state.clamped == s_r.ctrl.gnd_clamp
            && out_state.floated == (s_r.ctrl.dac_float && !s_r.ctrl.gnd_clamp)
            && out_state.normal == !(s_r.ctrl.dac_float || s_r.ctrl.gnd_clamp);
    endproperty
    a_state_decode: assert property (p_state_decode)
        else $error("output state does not match control bits");

    property p_clamp_wins;
        @(posedge pclk) disable iff (!presetn)
        s_r.ctrl.gnd_clamp |-> !out_state.floated && !out_state.ref_connect;
    endproperty
    a_clamp_wins: assert property (p_clamp_wins)
        else $error("clamp did not overrule float");

    property p_format;
        @(posedge pclk) disable iff (!presetn)
        dac_code == (s_r.ctrl.fmt_offset_bin ? s_r.dac
            : {~s_r.dac[DW-1], s_r.dac[DW-2:0]});
    endproperty
    a_format: assert property (p_format)
        else $error("output code ignores format select");

    property p_load;
        @(posedge pclk) disable iff (!presetn)
        sw_load && clr_pin && !clear_ev && !sw_reset
            |=> s_r.dac == $past(s_r.pend);
    endproperty
    a_load: assert property (p_load)
        else $error("load action did not move pending value");

    property p_clear_blocked;
        @(posedge pclk) disable iff (!presetn)
        ce && sw_clear && !ld_pin && !load_ev && !sw_reset
            |=> $stable(s_r.dac);
    endproperty
    a_clear_blocked: assert property (p_clear_blocked)
        else $error("clear acted while load pin low");

    property p_fb_sel;
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr && !sw_reset |=> out_state.fb_parallel
            == $past(pwdata[dosc_pkg::CTRL_FB]);
    endproperty
    a_fb_sel: assert property (p_fb_sel)
        else $error("feedback select not applied");

endmodule : dosc_ctrl

// [dosc_pkg.sv]
/*
 * shared constants and carrier types for the dac output state control block:
 * register offsets, field positions, reset values and the output-state bundle.
 * assumes a 32-bit apb slave with byte addresses and one register per word.
 */
package dosc_pkg;

    // code width of the dac register
    localparam int DAC_W = 20;

    // register byte offsets
    localparam logic [7:0] ADDR_PEND = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CLRCODE = 8'h08;
    localparam logic [7:0] ADDR_SWCTL = 8'h0c;
    localparam logic [7:0] ADDR_DAC = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // control register field positions
    localparam int CTRL_FB = 0;
    localparam int CTRL_FLOAT = 1;
    localparam int CTRL_CLAMP = 2;
    localparam int CTRL_FMT = 3;

    // software action bit positions
    localparam int SW_LOAD = 0;
    localparam int SW_CLEAR = 1;
    localparam int SW_RESET = 2;

    // dac and pending reset to the most negative twos complement code, i.e. the negative reference; clear code resets to zero
    localparam logic [DAC_W-1:0] DAC_RST = 20'h80000;
    localparam logic [DAC_W-1:0] PEND_RST = 20'h80000;
    localparam logic [DAC_W-1:0] CLRCODE_RST = 20'h00000;

    // control fields as they sit in the control register
    typedef struct packed {
        logic fmt_offset_bin;   // code_format_select
        logic gnd_clamp;        // out_ground_clamp
        logic dac_float;        // dac_float_ctl
        logic fb_sel;           // feedback_res_select
    } dosc_ctrl_type;

    // power-on control: floated and clamped, twos complement, gain of two
    localparam dosc_ctrl_type CTRL_RST = '{
        fmt_offset_bin: 1'b0,
        gnd_clamp: 1'b1,
        dac_float: 1'b1,
        fb_sel: 1'b0
    };

    // decoded analog state, as it sits in the status register
    typedef struct packed {
        logic fb_parallel;  // feedback resistors in parallel
        logic ref_connect;  // reference inputs connected
        logic clamped;      // output tied to analog_ground via ~6 kohm
        logic floated;      // output in tristate
        logic normal;       // output follows the code
    } dosc_ostate_type;

endpackage : dosc_pkg

// [dosc_sync.sv]
/*
 * two flip-flop synchroniser for the external active-low pins.
 * assumes pins idle high; reset state is therefore all ones.
 */
module dosc_sync #(
    parameter int W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } dosc_sync_st_type;

    dosc_sync_st_type s_r;
    dosc_sync_st_type s_nxt;

    if (W < 1)
    begin : g_chk
        $error("dosc_sync: width must be at least one");
    end

    // meta stage feeds only the second stage
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.meta = d;
        s_nxt.sync = s_r.meta;
    end

    // frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '1;
        else if (ce)
            s_r <= s_nxt;
    end

    assign q = s_r.sync;

endmodule : dosc_sync

// [dosc_host.sv]
/*
 * apb host model that programs the dac output state control registers.
 * assumes an apb slave on pclk that may insert wait states.
 */
module dosc_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus idle from time zero
    initial
    begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
    end

    // one transfer: setup, then access held until pready is sampled high or 50 access cycles pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n;
        hung = 1'b1;
        rd = 32'h0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50 && hung; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                err = pslverr;
                hung = 1'b0;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : dosc_host

// [tb_dac_output_state_control.sv]
/*
 * self-checking bench for the dac output state control block.
 * assumes the apb host model dosc_host and the package dosc_pkg.
 */
module tb_dac_output_state_control;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] er;
        logic [19:0] ec;
    } dosc_row_type;

    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic load_n, clear_n, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [19:0] dac_code;
    dosc_pkg::dosc_ostate_type out_state;
    int n_errors, tests_run;

    // write, then read back and check the code
    dosc_row_type rows [12] = '{
        '{dosc_pkg::ADDR_CTRL, 32'h6, dosc_pkg::ADDR_STAT, 32'h04, 20'h0},
        '{dosc_pkg::ADDR_CTRL, 32'h4, dosc_pkg::ADDR_STAT, 32'h04, 20'h0},
        '{dosc_pkg::ADDR_CTRL, 32'h2, dosc_pkg::ADDR_STAT, 32'h02, 20'h0},
        '{dosc_pkg::ADDR_CTRL, 32'h0, dosc_pkg::ADDR_STAT, 32'h09, 20'h0},
        '{dosc_pkg::ADDR_CTRL, 32'h1, dosc_pkg::ADDR_STAT, 32'h19, 20'h0},
        '{dosc_pkg::ADDR_PEND, 32'h12345, dosc_pkg::ADDR_PEND, 32'h12345, 20'h0},
        '{dosc_pkg::ADDR_SWCTL, 32'h1, dosc_pkg::ADDR_DAC, 32'h12345, 20'h92345},
        '{dosc_pkg::ADDR_CTRL, 32'h8, dosc_pkg::ADDR_STAT, 32'h09, 20'h12345},
        '{dosc_pkg::ADDR_CLRCODE, 32'habc, dosc_pkg::ADDR_CLRCODE, 32'habc, 20'h12345},
        '{dosc_pkg::ADDR_SWCTL, 32'h2, dosc_pkg::ADDR_DAC, 32'habc, 20'h00abc},
        '{dosc_pkg::ADDR_CTRL, 32'h0, dosc_pkg::ADDR_STAT, 32'h09, 20'h80abc},
        '{dosc_pkg::ADDR_SWCTL, 32'h1, dosc_pkg::ADDR_SWCTL, 32'h0, 20'h92345}
    };

    always #50 pclk = ~pclk;

    dosc_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    dosc_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_output_n(load_n),
        .clear_to_code_n(clear_n), .dac_code(dac_code), .out_state(out_state));

    // verdict and end of run
    task automatic close_out();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // compare a register word
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // compare the output code
    task automatic chk_code(input logic [19:0] exp);
        tests_run++;
        if (dac_code !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: code %h expected %h", $time, dac_code, exp);
        end
    endtask : chk_code

    // one bus transfer; a hang ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic h;
        host.xfer(w, a, d, rdat, rerr, h);
        if (h)
        begin
            n_errors++;
            $display("mismatch at %0t: bus hang", $time);
            close_out();
        end
    endtask : bus

    // read a register and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_word(rdat, exp);
    endtask : rd_chk

    // set both pins, then let the synchroniser and update settle
    task automatic pin(input logic l, input logic c);
        load_n <= l;
        clear_n <= c;
        repeat (6) @(posedge pclk);
    endtask : pin

    // power-on register values and output state
    task automatic defaults();
        rd_chk(dosc_pkg::ADDR_PEND, 32'h80000);
        rd_chk(dosc_pkg::ADDR_CTRL, 32'h6);
        rd_chk(dosc_pkg::ADDR_CLRCODE, 32'h0);
        rd_chk(dosc_pkg::ADDR_DAC, 32'h80000);
        rd_chk(dosc_pkg::ADDR_STAT, 32'h04);
        chk_word({27'h0, out_state}, 32'h4);
        chk_code(20'h0);
    endtask : defaults

    // main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        load_n = 1'b1;
        clear_n = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        defaults();
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].wa, rows[i].wd);
            rd_chk(rows[i].ra, rows[i].er);
            if (rows[i].ra == dosc_pkg::ADDR_STAT)
                chk_word({27'h0, out_state}, rows[i].er);
            chk_code(rows[i].ec);
        end
        // unmapped place and read-only place
        bus(1'b0, 8'h18, 32'h0);
        chk_word({31'h0, rerr}, 32'h1);
        chk_word(rdat, 32'h0);
        bus(1'b1, dosc_pkg::ADDR_DAC, 32'h5);
        rd_chk(dosc_pkg::ADDR_DAC, 32'h12345);
        // pin load, then pin clear
        bus(1'b1, dosc_pkg::ADDR_PEND, 32'h11111);
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        rd_chk(dosc_pkg::ADDR_DAC, 32'h11111);
        pin(1'b1, 1'b0);
        rd_chk(dosc_pkg::ADDR_DAC, 32'habc);
        // loads refused while clear pin low
        bus(1'b1, dosc_pkg::ADDR_PEND, 32'h22222);
        bus(1'b1, dosc_pkg::ADDR_SWCTL, 32'h1);
        pin(1'b0, 1'b0);
        rd_chk(dosc_pkg::ADDR_DAC, 32'habc);
        // clear refused while load pin low
        pin(1'b0, 1'b1);
        bus(1'b1, dosc_pkg::ADDR_CLRCODE, 32'h333);
        bus(1'b1, dosc_pkg::ADDR_SWCTL, 32'h2);
        rd_chk(dosc_pkg::ADDR_DAC, 32'habc);
        pin(1'b1, 1'b1);
        bus(1'b1, dosc_pkg::ADDR_SWCTL, 32'h2);
        rd_chk(dosc_pkg::ADDR_DAC, 32'h333);
        // pin pulse while frozen is never seen
        ce <= 1'b0;
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        ce <= 1'b1;
        rd_chk(dosc_pkg::ADDR_DAC, 32'h333);
        // software reset back to power-on state
        bus(1'b1, dosc_pkg::ADDR_SWCTL, 32'h4);
        repeat (2) @(posedge pclk);
        defaults();
        // pin reset in mid-run after leaving the clamp
        bus(1'b1, dosc_pkg::ADDR_CTRL, 32'h0);
        @(posedge pclk);
        chk_word({27'h0, out_state}, 32'h9);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk_word({27'h0, out_state}, 32'h4);
        presetn <= 1'b1;
        defaults();
        close_out();
    end
endmodule : tb_dac_output_state_control
